// [rtl/dcspo_map.vh]
// constants for the dual channel safe power off block
// assumes a 50 MHz system clock
`ifndef DCSPO_MAP_VH
`define DCSPO_MAP_VH
`define DCSPO_CLK_HZ 50000000
`define DCSPO_TICK_US 1000
`define DCSPO_TICK_CYC ((`DCSPO_CLK_HZ / 1000000) * `DCSPO_TICK_US)
`define DCSPO_FILT_MS 2
`define DCSPO_RESP_MS 15
`define DCSPO_MS_W 5
`define DCSPO_MODE_NO_ALARM 1'b0
`define DCSPO_RESTORE_EDGE 1'b0
`define DCSPO_RESTORE_LEVEL 1'b1
`define DCSPO_ST_RUN 2'h0
`define DCSPO_ST_OFF 2'h1
`define DCSPO_ST_HOLD 2'h2
`define DCSPO_BLINK_MS 250
`endif

// [rtl/dcspo_chan.v]
// one shut-off channel: synchroniser and off-pulse filter
// assumes tick is a one-cycle pulse every millisecond
`timescale 1ns/1ns
`include "dcspo_map.vh"
module dcspo_chan #(
    parameter FILT_MS = `DCSPO_FILT_MS
) (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire tick,
    input wire raw_in,
    output reg sync_out,
    output reg off_out
);
    reg meta_reg;
    reg [`DCSPO_MS_W-1:0] cnt_reg;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= 1'b1;
            sync_out <= 1'b1;
            cnt_reg <= {`DCSPO_MS_W{1'b0}};
            off_out <= 1'b0;
        end else if (ce) begin
            meta_reg <= raw_in; // R19
            sync_out <= meta_reg;
            // off only after low across more than FILT_MS full ticks
            if (sync_out) begin
                cnt_reg <= {`DCSPO_MS_W{1'b0}};
                off_out <= 1'b0;
            end else if (tick && !off_out) begin
                if (cnt_reg == FILT_MS[`DCSPO_MS_W-1:0]) begin
                    off_out <= 1'b1; // R04
                end else begin
                    cnt_reg <= cnt_reg + 1'b1;
                end
            end
        end
    end
endmodule // dcspo_chan

// [rtl/dcspo_top.v]
// Summary of operation
// R01 - both inputs off: remove power, block drive
// R02 - power removed within 15 ms
// R03 - partner holds both off 15 ms
// R04 - off pulses of 1 ms ignored
// R05 - partner test pulses 1 ms or less
// R06 - removed, mode 0: monitor on, readies off
// R07 - removed: led blinks green, brake held
// R08 - both back on: release, stay unexcited
// R09 - one input back does not release
// R10 - partner holds both on 15 ms
// R11 - re-excite only on restore input
// R12 - re-excite: outputs on, led steady, brake free
// R13 - shutoff monitor only when both off
// R14 - partner checks monitor pairing
// R15 - single channel off: monitor off, unexcited
// R16 - partner releases only with monitor on
// R17 - safety module resets on monitor feedback
// R18 - channel a upper arm, b lower arm
// R19 - synchronise inputs, millisecond timebase
//
// top of the dual channel safe power off logic
// assumes inputs synchronous-capable, 50 MHz clk, high = input on
`timescale 1ns/1ns
`include "dcspo_map.vh"
module dcspo_top #(
    parameter TICK_CYC = `DCSPO_TICK_CYC,
    parameter FILT_MS = `DCSPO_FILT_MS,
    parameter BLINK_MS = `DCSPO_BLINK_MS
) (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire safe_off_in_a,
    input wire safe_off_in_b,
    input wire excitation_restore_in,
    input wire safe_off_alarm_mode,
    input wire restore_level_mode,
    output reg upper_arm_enable,
    output reg lower_arm_enable,
    output reg shutoff_monitor_out,
    output reg excitation_off_monitor,
    output reg ready,
    output reg pulse_input_ready,
    output reg brake_release_ctrl,
    output reg power_alarm_led,
    output reg excited
);
    localparam [1:0] ST_RUN = `DCSPO_ST_RUN;
    localparam [1:0] ST_OFF = `DCSPO_ST_OFF;
    localparam [1:0] ST_HOLD = `DCSPO_ST_HOLD;

    // bits to count 0 to value-1, at least one
    function integer cnt_bits;
        input integer value;
        integer v;
        begin
            v = value - 1;
            cnt_bits = 1;
            while (v > 1) begin
                v = v >> 1;
                cnt_bits = cnt_bits + 1;
            end
        end
    endfunction

    // either channel filtered off
    function any_off;
        input [1:0] off;
        begin
            any_off = off[0] | off[1];
        end
    endfunction

    // state decodes to an excited motor
    function is_run;
        input [1:0] st;
        begin
            is_run = (st == ST_RUN);
        end
    endfunction

    localparam integer TICK_W = cnt_bits(TICK_CYC);
    localparam integer TICK_M1 = TICK_CYC - 1;
    localparam [TICK_W-1:0] TICK_LAST = TICK_M1[TICK_W-1:0];
    localparam integer BLINK_W = cnt_bits(BLINK_MS);
    localparam integer BLINK_M1 = BLINK_MS - 1;
    localparam [BLINK_W-1:0] BLINK_LAST = BLINK_M1[BLINK_W-1:0];

    reg [TICK_W-1:0] tick_cnt_reg;
    reg tick_reg;
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg rst_meta_reg;
    reg rst_sync_reg;
    reg rst_prev_reg;
    reg [BLINK_W-1:0] blink_cnt_reg;
    reg blink_reg;
    wire [1:0] sync_w;
    wire [1:0] off_w;
    wire [1:0] raw_w;
    wire restore_hit;

    assign raw_w = {safe_off_in_b, safe_off_in_a};

    // millisecond timebase
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_cnt_reg <= {TICK_W{1'b0}};
            tick_reg <= 1'b0;
        end else if (ce) begin
            if (tick_cnt_reg == TICK_LAST) begin
                tick_cnt_reg <= {TICK_W{1'b0}};
                tick_reg <= 1'b1; // R19
            end else begin
                tick_cnt_reg <= tick_cnt_reg + 1'b1;
                tick_reg <= 1'b0;
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_chan
            dcspo_chan #(
                .FILT_MS(FILT_MS)
            ) u_chan (
                .clk(clk),
                .rst(rst),
                .ce(ce),
                .tick(tick_reg),
                .raw_in(raw_w[gi]),
                .sync_out(sync_w[gi]),
                .off_out(off_w[gi])
            );
        end
    endgenerate

    // restore input sync and edge/level select
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
            rst_prev_reg <= 1'b0;
        end else if (ce) begin
            rst_meta_reg <= excitation_restore_in; // R19
            rst_sync_reg <= rst_meta_reg;
            rst_prev_reg <= rst_sync_reg;
        end
    end

    assign restore_hit = (restore_level_mode == `DCSPO_RESTORE_LEVEL) ? rst_sync_reg :
        (rst_sync_reg & ~rst_prev_reg); // R11

    // excitation state machine
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN: begin
                if (any_off(off_w)) begin
                    state_next = ST_OFF; // R15
                end
            end
            ST_OFF: begin
                if (sync_w[0] & sync_w[1] & ~any_off(off_w)) begin
                    state_next = ST_HOLD; // R08 R09
                end
            end
            ST_HOLD: begin
                if (any_off(off_w)) begin
                    state_next = ST_OFF;
                end else if (restore_hit) begin
                    state_next = ST_RUN; // R11
                end
            end
            default: begin
                state_next = ST_OFF;
            end
        endcase
    end

    // blink timebase for the led
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            blink_cnt_reg <= {BLINK_W{1'b0}};
            blink_reg <= 1'b0;
        end else if (ce && tick_reg) begin
            if (blink_cnt_reg == BLINK_LAST) begin
                blink_cnt_reg <= {BLINK_W{1'b0}};
                blink_reg <= ~blink_reg;
            end else begin
                blink_cnt_reg <= blink_cnt_reg + 1'b1;
            end
        end
    end

    // state and registered outputs
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_OFF;
            upper_arm_enable <= 1'b0;
            lower_arm_enable <= 1'b0;
            shutoff_monitor_out <= 1'b0;
            excitation_off_monitor <= 1'b0;
            ready <= 1'b0;
            pulse_input_ready <= 1'b0;
            brake_release_ctrl <= 1'b0;
            power_alarm_led <= 1'b0;
            excited <= 1'b0;
        end else if (ce) begin
            state_reg <= state_next;
            upper_arm_enable <= ~off_w[0] & is_run(state_next); // R18 R01 R02
            lower_arm_enable <= ~off_w[1] & is_run(state_next); // R18 R01
            shutoff_monitor_out <= off_w[0] & off_w[1]; // R13 R15
            excited <= is_run(state_next); // R08
            if (is_run(state_next)) begin
                excitation_off_monitor <= 1'b0; // R12
                ready <= 1'b1;
                pulse_input_ready <= 1'b1;
                brake_release_ctrl <= 1'b1;
                power_alarm_led <= 1'b1;
            end else begin
                excitation_off_monitor <= (safe_off_alarm_mode == `DCSPO_MODE_NO_ALARM); // R06
                ready <= 1'b0; // R06
                pulse_input_ready <= 1'b0;
                brake_release_ctrl <= 1'b0; // R07
                power_alarm_led <= blink_reg; // R07
            end
        end
    end
endmodule // dcspo_top

// [bench/dcspo_safety_mod.sv]
// model of the external safety module driving both shut-off channels
// assumes bench drives controls just after a rising clk edge
`timescale 1ns/1ns
module dcspo_safety_mod (
    input wire clk,
    input wire off_req,
    input wire pulse_a,
    input wire pulse_b,
    input wire feedback,
    output wire chan_a,
    output wire chan_b
);
    reg hold_reg = 1'b0;
    always @(posedge clk) begin
        if (off_req) begin
            hold_reg <= 1'b1;
        end else if (feedback) begin
            hold_reg <= 1'b0;
        end
    end
    // bench keeps test pulses at 1 ms or less
    assign chan_a = ~(hold_reg | off_req | pulse_a);
    assign chan_b = ~(hold_reg | off_req | pulse_b);
endmodule // dcspo_safety_mod

// [bench/dcspo_top_props.sv]
// port checker for dcspo_top
// assumes 1 ms equals ten clk cycles and ce low only briefly
`timescale 1ns/1ns
module dcspo_top_props (
    input wire clk,
    input wire rst,
    input wire safe_off_in_a,
    input wire safe_off_in_b,
    input wire excitation_restore_in,
    input wire upper_arm_enable,
    input wire lower_arm_enable,
    input wire shutoff_monitor_out,
    input wire excitation_off_monitor,
    input wire ready,
    input wire pulse_input_ready,
    input wire brake_release_ctrl,
    input wire power_alarm_led,
    input wire excited
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_restore;
        $past(excitation_restore_in, 3) && safe_off_in_a && safe_off_in_b;
    endsequence
    a_mon_blocks: assert property (shutoff_monitor_out |-> !excited && !upper_arm_enable
        && !lower_arm_enable) else $error("monitor high while drive enabled");
    a_ready_tie: assert property (ready == excited && pulse_input_ready == excited
        && brake_release_ctrl == excited) else $error("ready outputs differ from excited");
    a_off_mon: assert property (excitation_off_monitor |-> !excited)
        else $error("off monitor high while excited");
    a_led_steady: assert property (excited && $past(excited) |-> power_alarm_led)
        else $error("led not steady while excited");
    a_upper_block: assert property ($fell(safe_off_in_a) |-> ##[1:150]
        (!upper_arm_enable || safe_off_in_a)) else $error("upper arm not blocked");
    a_lower_block: assert property ($fell(safe_off_in_b) |-> ##[1:150]
        (!lower_arm_enable || safe_off_in_b)) else $error("lower arm not blocked");
    a_excite_cause: assert property ($rose(excited) |-> s_restore)
        else $error("excited without restore");
    a_mon_one_on: assert property (safe_off_in_a [*6] |-> !shutoff_monitor_out)
        else $error("monitor high with channel a on");
endmodule // dcspo_top_props
bind dcspo_top dcspo_top_props u_props (.clk(clk), .rst(rst), .safe_off_in_a(safe_off_in_a),
    .safe_off_in_b(safe_off_in_b), .excitation_restore_in(excitation_restore_in),
    .upper_arm_enable(upper_arm_enable), .lower_arm_enable(lower_arm_enable),
    .shutoff_monitor_out(shutoff_monitor_out), .excitation_off_monitor(excitation_off_monitor),
    .ready(ready), .pulse_input_ready(pulse_input_ready),
    .brake_release_ctrl(brake_release_ctrl), .power_alarm_led(power_alarm_led),
    .excited(excited));

// [bench/dcspo_top_tb.sv]
// testbench for dcspo_top with a safety module model
// assumes 1 ms shortened to 10 cycles
`timescale 1ns/1ns
module dcspo_top_tb;
    reg clk = 1'b0, rst = 1'b1, ce = 1'b1, res = 1'b0, lvl = 1'b0, mode = 1'b0;
    reg off_req = 1'b0, pa = 1'b0, pb = 1'b0, l0;
    wire a, b, ua, la, mon, eom, rdy, prdy, brk, led, exc;
    wire [7:0] st = {exc, rdy, prdy, brk, ua, la, eom, mon};
    integer errors = 0, compares = 0, i;
    always #10 clk = ~clk;
    dcspo_safety_mod u_sm (.clk(clk), .off_req(off_req), .pulse_a(pa), .pulse_b(pb),
        .feedback(mon), .chan_a(a), .chan_b(b));
    dcspo_top #(.TICK_CYC(10), .FILT_MS(2), .BLINK_MS(2)) u_dut (.clk(clk), .rst(rst),
        .ce(ce), .safe_off_in_a(a), .safe_off_in_b(b), .excitation_restore_in(res),
        .safe_off_alarm_mode(mode), .restore_level_mode(lvl), .upper_arm_enable(ua),
        .lower_arm_enable(la), .shutoff_monitor_out(mon), .excitation_off_monitor(eom),
        .ready(rdy), .pulse_input_ready(prdy), .brake_release_ctrl(brk),
        .power_alarm_led(led), .excited(exc));
    task chk(input string n, input [7:0] e, input [7:0] s);
        begin
            compares = compares + 1;
            if (s !== e) begin
                errors = errors + 1;
                $display("[FAIL] %s expected %h seen %h", n, e, s);
            end
        end
    endtask
    task wt(input integer n);
        repeat (n) @(posedge clk);
    endtask
    task restore;
        begin
            res <= 1'b1;
            wt(6);
            res <= 1'b0;
            wt(2);
        end
    endtask
    task t_excite;
        begin
            chk("released", 8'h02, st);
            restore();
            chk("excited", 8'hfc, st);
            chk("led", 8'h01, {7'h0, led});
            $display("excite done");
        end
    endtask
    task t_freeze;
        begin
            ce <= 1'b0;
            pa <= 1'b1;
            wt(40);
            chk("frozen", 8'hfc, st);
            pa <= 1'b0;
            ce <= 1'b1;
            wt(40);
            chk("thawed", 8'hfc, st);
            $display("freeze done");
        end
    endtask
    task t_pulse;
        begin
            for (i = 0; i < 2; i = i + 1) begin
                {pa, pb} <= i ? 2'b01 : 2'b10;
                wt(10);
                {pa, pb} <= 2'b00;
                wt(40);
                chk("pulse", 8'hfc, st);
            end
            $display("pulse done");
        end
    endtask
    task t_single;
        begin
            pa <= 1'b1;
            wt(150);
            chk("single", 8'h02, st);
            restore();
            chk("single restore", 8'h02, st);
            pa <= 1'b0;
            wt(160);
            restore();
            chk("single back", 8'hfc, st);
            $display("single done");
        end
    endtask
    task t_remove;
        begin
            off_req <= 1'b1;
            wt(150);
            chk("removed", 8'h03, st);
            l0 = led;
            wt(20);
            chk("blink", {7'h0, ~l0}, {7'h0, led});
            mode <= 1'b1;
            wt(3);
            chk("alarm mode", 8'h01, st);
            mode <= 1'b0;
            off_req <= 1'b0;
            lvl <= 1'b1;
            wt(160);
            chk("release", 8'h02, st);
            restore();
            chk("level restore", 8'hfc, st);
            $display("remove done");
        end
    endtask
    task test_done;
        begin
            $display("errors %0d compares %0d", errors, compares);
            if (errors == 0 && compares > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    initial begin
        wt(6);
        rst <= 1'b0;
        wt(160);
        t_excite();
        t_freeze();
        t_pulse();
        t_single();
        t_remove();
        test_done();
    end
endmodule // dcspo_top_tb
